// >>> design/spd_eeprom.sv
// Presence-detect EEPROM slave: bus engine, array, page buffer and protection
`timescale 1ns/10ps

module spd_eeprom #(
	parameter int P_WR_CYCLES = spd_pkg::TWR_CYCLES      // Write cycle length in clocks
) (
	input  wire logic       I_CLK_SYS,                   // System clock, 200 MHz
	input  wire logic       I_RST_B,                     // Async reset, active low
	input  wire logic       I_SCL,                       // Bus clock from master
	input  wire logic       I_SDA,                       // Bus data line level
	output logic            O_SDA,                       // Bus data drive value, always low
	output logic            O_SDA_OE,                    // High while pulling data low
	input  wire logic [2:0] I_ADDR_SEL,                  // Select pins, bit0 first
	input  wire logic       I_ADDR0_HV,                  // Select bit0 at extra-high level
	input  wire logic       I_WP,                        // Write protect pin
	output logic            O_BUSY,                      // Internal write cycle running
	input  wire logic [1:0] I_REG_ADDR,                  // Register address
	input  wire logic [7:0] I_REG_WDATA,                 // Register write data
	input  wire logic       I_REG_WR,                    // Register write strobe
	input  wire logic       I_REG_RD,                    // Register read strobe
	output logic      [7:0] O_REG_RDATA                  // Read data, cycle after strobe
);
	import spd_pkg::*;

	// Synchroniser stages and edge history
	logic [2:0]       scl_sync;                          // SCL stages, [2] is history
	logic [2:0]       sda_sync;                          // SDA stages, [2] is history
	logic [1:0]       wp_sync;                           // Protect pin stages
	logic [1:0]       sel_sync [3];                      // Select pin stages
	logic [1:0]       hv_sync;                           // High-voltage detect stages
	// Engine state
	spd_state_t       state, next_state;                 // Bus engine state
	spd_state_t       after, next_after;                 // State after acknowledge slot
	spd_cmd_t         cmd, next_cmd;                     // Current command kind
	logic [3:0]       bit_cnt, next_bit_cnt;             // Bit position in byte or slot
	logic [7:0]       shreg, next_shreg;                 // Shift register
	logic             ack_pend, next_ack_pend;           // Acknowledge to give in slot
	logic             sda_oe, next_sda_oe;               // Data pull-down
	logic [7:0]       ptr, next_ptr;                     // Internal address counter
	logic             wr_pend, next_wr_pend;             // Write cycle owed at Stop
	logic             busy, next_busy;                   // Write cycle running
	logic [BUSY_W-1:0] busy_cnt, next_busy_cnt;          // Cycles left in write cycle
	logic             commit;                            // Last cycle of write cycle
	// Page buffer control
	logic             buf_we;                            // Store a byte in page buffer
	logic             buf_clr;                           // Forget buffered bytes
	logic [7:0]       page_buf [PAGE_BYTES];             // Bytes awaiting programming
	logic [PAGE_BYTES-1:0] buf_mask;                     // Slots holding new data
	// Array and flags
	logic [7:0]       mem [MEM_DEPTH];                   // The array itself
	logic             rev_flag;                          // reversible_protect_flag
	logic             perm_flag;                         // permanent_protect_flag
	// Register port
	logic [7:0]       peek_addr;                         // Inspection pointer
	logic [7:0]       reg_rdata;                         // Read data register
	// Decoded conditions
	logic             scl_rise, scl_fall, sda_in;
	logic             bus_start, bus_stop;
	logic [7:0]       rx_byte;                           // Byte completed this edge
	logic [2:0]       sel;                               // Synchronised select pins
	logic             wp, hv;                            // Synchronised pin levels

	// Two flops on every pin before use
	always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
		if (!I_RST_B) begin
			scl_sync <= 3'h7;
			sda_sync <= 3'h7;
			wp_sync  <= 2'h0;
			hv_sync  <= 2'h0;
			for (int i = 0; i < 3; i++) begin
				sel_sync[i] <= 2'h0;
			end
		end else begin
			scl_sync <= {scl_sync[1:0], I_SCL};
			sda_sync <= {sda_sync[1:0], I_SDA};
			wp_sync  <= {wp_sync[0], I_WP};
			hv_sync  <= {hv_sync[0], I_ADDR0_HV};
			for (int i = 0; i < 3; i++) begin
				sel_sync[i] <= {sel_sync[i][0], I_ADDR_SEL[i]};
			end
		end
	end

	// Edge and condition detection on second and third stages
	always_comb begin
		scl_rise  = scl_sync[1] & ~scl_sync[2];
		scl_fall  = ~scl_sync[1] & scl_sync[2];
		sda_in    = sda_sync[1];
		bus_start = scl_sync[1] & scl_sync[2] & sda_sync[2] & ~sda_sync[1];
		bus_stop  = scl_sync[1] & scl_sync[2] & ~sda_sync[2] & sda_sync[1];
		rx_byte   = {shreg[6:0], sda_in};
		sel       = {sel_sync[2][1], sel_sync[1][1], sel_sync[0][1]};
		wp        = wp_sync[1];
		hv        = hv_sync[1];
	end

	// Next-state logic of the bus engine
	always_comb begin
		next_state    = state;
		next_after    = after;
		next_cmd      = cmd;
		next_bit_cnt  = bit_cnt;
		next_shreg    = shreg;
		next_ack_pend = ack_pend;
		next_sda_oe   = sda_oe;
		next_ptr      = ptr;
		next_wr_pend  = wr_pend;
		next_busy     = busy;
		next_busy_cnt = busy_cnt;
		commit        = 1'b0;
		buf_we        = 1'b0;
		buf_clr       = 1'b0;
		if (busy) begin
			next_busy_cnt = busy_cnt - BUSY_W'(1);
			if (busy_cnt == BUSY_W'(1)) begin
				commit    = 1'b1;
				next_busy = 1'b0;
			end
		end
		if (bus_start) begin
			next_state   = busy ? ST_IDLE : ST_DEV;
			next_bit_cnt = 4'h0;
			next_sda_oe  = 1'b0;
			next_wr_pend = 1'b0;
		end else if (bus_stop) begin
			if (wr_pend && !busy) begin
				next_busy     = 1'b1;
				next_busy_cnt = BUSY_W'(P_WR_CYCLES);
			end
			next_wr_pend = 1'b0;
			next_state   = ST_IDLE;
			next_sda_oe  = 1'b0;
		end else begin
			unique case (state)
				ST_IDLE, ST_WAIT: begin                  // Idle or waiting for next Start
					next_sda_oe = 1'b0;
				end
				ST_DEV, ST_WORD, ST_DATA: begin          // Receive one byte, MSB first
					if (scl_rise) begin
						next_shreg   = rx_byte;
						next_bit_cnt = bit_cnt + 4'h1;
						if (bit_cnt == 4'h7) begin
							next_bit_cnt = 4'h0;
							next_state   = ST_ACK;
							next_ack_pend = 1'b0;
							next_after   = ST_WAIT;
							if (state == ST_DEV) begin
								if (rx_byte[DEV_PFX_MSB:DEV_PFX_LSB] == PFX_ARRAY &&
								    rx_byte[DEV_SEL_MSB:DEV_SEL_LSB] == sel) begin
									next_ack_pend = 1'b1;
									next_cmd   = rx_byte[DEV_RW_BIT] ? CMD_NORM_R : CMD_NORM_W;
									next_after = rx_byte[DEV_RW_BIT] ? ST_RD : ST_WORD;
								end else if (rx_byte[DEV_PFX_MSB:DEV_PFX_LSB] == PFX_PROTECT &&
								             !perm_flag) begin
									if (hv && rx_byte[DEV_SEL_MSB] == 1'b0 &&
									    rx_byte[DEV_SEL_LSB] == 1'b1) begin
										if (rx_byte[REV_SET_BIT] == 1'b0) begin
											next_ack_pend = ~rev_flag;
											next_cmd = rx_byte[DEV_RW_BIT] ? CMD_STATUS : CMD_SET_REV;
										end else begin
											next_ack_pend = 1'b1;
											next_cmd = rx_byte[DEV_RW_BIT] ? CMD_STATUS : CMD_CLR_REV;
										end
										next_after = rx_byte[DEV_RW_BIT] ? ST_WAIT : ST_WORD;
									end else if (rx_byte[DEV_SEL_MSB:DEV_SEL_LSB] == sel) begin
										// permanent set or status, select bits matched
										next_ack_pend = 1'b1;
										next_cmd   = rx_byte[DEV_RW_BIT] ? CMD_STATUS : CMD_SET_PERM;
										next_after = rx_byte[DEV_RW_BIT] ? ST_WAIT : ST_WORD;
									end
								end
							end else if (state == ST_WORD) begin
								next_ack_pend = 1'b1;
								next_after    = ST_DATA;
								buf_clr       = 1'b1;
								if (cmd == CMD_NORM_W) begin
									next_ptr = rx_byte;
								end
							end else if (cmd == CMD_NORM_W) begin
								if (wp || (ptr < UPPER_HALF && (rev_flag || perm_flag))) begin
									next_wr_pend = 1'b0;
								end else begin
									next_ack_pend = 1'b1;
									next_after    = ST_DATA;
									next_wr_pend  = 1'b1;
									buf_we        = 1'b1;
									next_ptr      = {ptr[7:4], ptr[3:0] + 4'h1};
								end
							end else begin
								next_ack_pend = ~wp;
								next_after    = ST_DATA;
								next_wr_pend  = ~wp;
							end
						end
					end
				end
				ST_ACK: begin                            // Ack slot, then release or read
					if (scl_fall) begin
						if (bit_cnt == 4'h0) begin
							next_sda_oe  = ack_pend;
							next_bit_cnt = 4'h1;
						end else if (ack_pend && after == ST_RD) begin
							// current read returns byte at counter
							next_shreg   = mem[ptr];
							next_ptr     = ptr + 8'h01;
							next_sda_oe  = ~mem[ptr][7];
							next_bit_cnt = 4'h1;
							next_state   = ST_RD;
						end else begin
							next_sda_oe  = 1'b0;
							next_bit_cnt = 4'h0;
							next_state   = ack_pend ? after : ST_WAIT;
						end
					end
				end
				ST_RD: begin                             // Shift out while clock low
					if (scl_fall) begin
						if (bit_cnt == 4'h8) begin
							next_sda_oe  = 1'b0;
							next_bit_cnt = 4'h0;
							next_state   = ST_MACK;
						end else begin
							next_sda_oe  = ~shreg[3'(4'h7 - bit_cnt)];
							next_bit_cnt = bit_cnt + 4'h1;
						end
					end
				end
				ST_MACK: begin                           // Master ack slot after read byte
					if (scl_rise) begin
						if (sda_in) begin
							next_state = ST_WAIT;
						end else begin
							next_bit_cnt = 4'h1;
						end
					end else if (scl_fall && bit_cnt == 4'h1) begin
						next_shreg   = mem[ptr];
						next_ptr     = ptr + 8'h01;
						next_sda_oe  = ~mem[ptr][7];
						next_state   = ST_RD;
					end
				end
			endcase
		end
	end

	// Engine registers
	always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
		if (!I_RST_B) begin
			state    <= ST_IDLE;
			after    <= ST_IDLE;
			cmd      <= CMD_NORM_W;
			bit_cnt  <= 4'h0;
			shreg    <= 8'h00;
			ack_pend <= 1'b0;
			sda_oe   <= 1'b0;
			ptr      <= PTR_RST;
			wr_pend  <= 1'b0;
			busy     <= 1'b0;
			busy_cnt <= '0;
		end else begin
			state    <= next_state;
			after    <= next_after;
			cmd      <= next_cmd;
			bit_cnt  <= next_bit_cnt;
			shreg    <= next_shreg;
			ack_pend <= next_ack_pend;
			sda_oe   <= next_sda_oe;
			ptr      <= next_ptr;
			wr_pend  <= next_wr_pend;
			busy     <= next_busy;
			busy_cnt <= next_busy_cnt;
		end
	end

	// Page buffer valid mask, one bit per slot
	always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
		if (!I_RST_B) begin
			buf_mask <= '0;
		end else if (buf_clr || commit) begin
			buf_mask <= '0;
		end else if (buf_we) begin
			buf_mask[ptr[3:0]] <= 1'b1;
		end
	end

	// Buffered data, no reset needed
	always_ff @(posedge I_CLK_SYS) begin
		if (buf_we) begin
			page_buf[ptr[3:0]] <= rx_byte;
		end
	end

	// buffered bytes of the page programmed at end of one normal write cycle
	always_ff @(posedge I_CLK_SYS) begin
		if (commit && cmd == CMD_NORM_W) begin
			for (int i = 0; i < PAGE_BYTES; i++) begin
				if (buf_mask[i]) begin
					mem[{ptr[7:4], 4'(i)}] <= page_buf[i];
				end
			end
		end
	end

	// permanent flag cleared only by delivery reset, reversible flag also by clear command
	always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
		if (!I_RST_B) begin
			rev_flag  <= FLAG_RST;
			perm_flag <= FLAG_RST;
		end else if (commit) begin
			if (cmd == CMD_SET_REV || cmd == CMD_CLR_REV) begin
				rev_flag <= (cmd == CMD_SET_REV);
			end
			if (cmd == CMD_SET_PERM) begin
				perm_flag <= 1'b1;
			end
		end
	end

	// Register port: inspection pointer and read data
	always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
		if (!I_RST_B) begin
			peek_addr <= 8'h00;
			reg_rdata <= 8'h00;
		end else begin
			if (I_REG_WR && I_REG_ADDR == REG_PEEK_ADDR) begin
				peek_addr <= I_REG_WDATA;
			end
			if (I_REG_RD) begin
				unique case (I_REG_ADDR)
					REG_STATUS: begin
						reg_rdata <= {4'h0, wp, perm_flag, rev_flag, busy};
					end
					REG_PEEK_ADDR: begin
						reg_rdata <= peek_addr;
					end
					REG_PEEK_DATA: begin
						reg_rdata <= mem[peek_addr];
					end
					default: begin
						reg_rdata <= 8'h00;
					end
				endcase
			end else begin
				reg_rdata <= 8'h00;
			end
		end
	end

	// Outputs straight from flops, data value tied low
	always_comb begin
		O_SDA       = 1'b0;
		O_SDA_OE    = sda_oe;
		O_BUSY      = busy;
		O_REG_RDATA = reg_rdata;
	end
endmodule

// >>> design/spd_pkg.sv
// Shared constants and types of the presence-detect EEPROM slave
package spd_pkg;
	// Array geometry
	localparam int          MEM_DEPTH     = 256;           // Bytes in the array
	localparam int          PAGE_BYTES    = 16;            // Bytes in one page
	localparam logic [7:0]  UPPER_HALF    = 8'h80;         // First byte of unprotectable half
	// Slave address fields
	localparam logic [3:0]  PFX_ARRAY     = 4'hA;          // Array prefix 1010
	localparam logic [3:0]  PFX_PROTECT   = 4'h6;          // Protection prefix 0110
	localparam int          DEV_PFX_MSB   = 7;             // Prefix top bit
	localparam int          DEV_PFX_LSB   = 4;             // Prefix low bit
	localparam int          DEV_SEL_MSB   = 3;             // Select field top bit
	localparam int          DEV_SEL_LSB   = 1;             // Select field low bit
	localparam int          DEV_RW_BIT    = 0;             // Direction bit, one reads
	localparam int          REV_SET_BIT   = 2;             // Zero sets, one clears
	// Reset values
	localparam logic [7:0]  PTR_RST       = 8'h00;         // Address counter at reset
	localparam logic        FLAG_RST      = 1'b0;          // Flags as delivered
	// Write cycle timing
	localparam int          CLK_PERIOD_NS = 5;             // System clock period
	localparam int          TWR_MS        = 5;             // Self-timed write cycle
	localparam int          TWR_CYCLES    = (TWR_MS * 1000000) / CLK_PERIOD_NS;
	localparam int          BUSY_W        = 20;            // Busy counter width
	// Software register port
	localparam logic [1:0]  REG_STATUS    = 2'h0;          // Busy, flags, protect pin level
	localparam logic [1:0]  REG_PEEK_ADDR = 2'h1;          // Array inspection pointer
	localparam logic [1:0]  REG_PEEK_DATA = 2'h2;          // Byte at inspection pointer
	localparam int          ST_BUSY_BIT   = 0;             // Status: write cycle running
	localparam int          ST_REV_BIT    = 1;             // Status: reversible flag
	localparam int          ST_PERM_BIT   = 2;             // Status: permanent flag
	localparam int          ST_WP_BIT     = 3;             // Status: protect pin level
	// Bus engine states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_DEV  = 3'b001,
		ST_ACK  = 3'b010,
		ST_WORD = 3'b011,
		ST_DATA = 3'b100,
		ST_RD   = 3'b101,
		ST_MACK = 3'b110,
		ST_WAIT = 3'b111
	} spd_state_t;
	// Decoded command kinds
	typedef enum logic [2:0] {
		CMD_NORM_W   = 3'b000,
		CMD_NORM_R   = 3'b001,
		CMD_SET_REV  = 3'b010,
		CMD_CLR_REV  = 3'b011,
		CMD_SET_PERM = 3'b100,
		CMD_STATUS   = 3'b101
	} spd_cmd_t;
endpackage

// >>> test/spd_eeprom_properties.sv
// Timing and register-port properties of the EEPROM slave seen at its ports
`timescale 1ns/10ps
module spd_eeprom_checker
	import spd_pkg::*;
#(
	parameter int P_WR_CYCLES = 50           // Write cycle length in clocks
) (
	input wire logic       I_CLK_SYS,        // System clock
	input wire logic       I_RST_B,          // Async reset, active low
	input wire logic       I_SCL,            // Bus clock
	input wire logic       I_SDA,            // Resolved data line
	input wire logic       O_SDA_OE,         // Device pulls data low
	input wire logic       O_BUSY,           // Write cycle running
	input wire logic       I_WP,             // Protect pin
	input wire logic [1:0] I_REG_ADDR,       // Register address
	input wire logic       I_REG_RD,         // Register read strobe
	input wire logic [7:0] O_REG_RDATA       // Register read data
);
	logic [31:0] busy_cnt;                   // Cycles busy has stood
	logic [31:0] next_busy_cnt;
	logic [7:0]  since_stop;                 // Cycles since last Stop
	logic [7:0]  next_since_stop;
	logic        sda_q;                      // Last data line sample
	logic        next_sda_q;
	// Busy length and age of the last Stop
	always_comb begin
		next_busy_cnt = O_BUSY ? busy_cnt + 32'h0000_0001 : 32'h0000_0000;
		next_sda_q = I_SDA;
		next_since_stop = (since_stop == 8'hFF) ? since_stop : since_stop + 8'h01;
		// Data rising while clock high
		if (I_SCL && I_SDA && !sda_q) begin
			next_since_stop = 8'h00;
		end
	end
	// Helper registers
	always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
		if (!I_RST_B) begin
			busy_cnt <= 32'h0000_0000;
			since_stop <= 8'hFF;
			sda_q <= 1'b1;
		end else begin
			busy_cnt <= next_busy_cnt;
			since_stop <= next_since_stop;
			sda_q <= next_sda_q;
		end
	end
	default clocking @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_RST_B);
	// Read strobe, then the answer cycle
	sequence s_rd(logic [1:0] a);
		I_REG_RD && I_REG_ADDR == a ##1 1'b1;
	endsequence
	a_busy_quiet: assert property (O_BUSY |-> !O_SDA_OE)
		else $error("Data line pulled during write cycle");
	a_busy_length: assert property ($fell(O_BUSY) |-> busy_cnt == 32'(P_WR_CYCLES))
		else $error("Write cycle length wrong");
	a_busy_after_stop: assert property ($rose(O_BUSY) |-> since_stop <= 8'h0A)
		else $error("Write cycle began without a Stop");
	a_wp_no_cycle: assert property ($rose(O_BUSY) |-> !I_WP)
		else $error("Write cycle began while protected");
	a_drive_stable: assert property (I_SCL && $past(I_SCL) |-> $stable(O_SDA_OE))
		else $error("Data drive changed while clock high");
	a_rdata_idle: assert property (!$past(I_REG_RD) |-> O_REG_RDATA == 8'h00)
		else $error("Read data outside answer cycle");
	a_status_busy: assert property (s_rd(REG_STATUS) |-> O_REG_RDATA[ST_BUSY_BIT] == $past(O_BUSY))
		else $error("Status busy bit wrong");
	a_unmapped_zero: assert property (s_rd(2'h3) |-> O_REG_RDATA == 8'h00)
		else $error("Unmapped read not zero");
endmodule
bind spd_eeprom spd_eeprom_checker #(.P_WR_CYCLES(P_WR_CYCLES)) u_chk (
	.I_CLK_SYS(I_CLK_SYS), .I_RST_B(I_RST_B), .I_SCL(I_SCL), .I_SDA(I_SDA),
	.O_SDA_OE(O_SDA_OE), .O_BUSY(O_BUSY), .I_WP(I_WP), .I_REG_ADDR(I_REG_ADDR),
	.I_REG_RD(I_REG_RD), .O_REG_RDATA(O_REG_RDATA)
);

// >>> test/spd_i2c_master.sv
// Bus master model that drives the two-wire link
`timescale 1ns/10ps
module spd_i2c_master (
	output logic      o_scl,                 // Bus clock, high when idle
	output logic      o_sda,                 // Data drive, one releases
	input  wire logic i_sda                  // Resolved data line
);
	localparam time Q = 16;                  // Quarter of a 64 ns bit
	// Idle bus
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	// One bit: data moves in low phase, sampled in high phase
	task automatic bit_x(input logic b, output logic r);
		#Q o_sda = b;
		#Q o_scl = 1'b1;
		#Q r = i_sda;
		#Q o_scl = 1'b0;
	endtask
	// Start or repeated Start
	task automatic start();
		#Q o_sda = 1'b1;
		#Q o_scl = 1'b1;
		#Q o_sda = 1'b0;
		#Q o_scl = 1'b0;
	endtask
	// Stop closes a transfer, clock then stands high
	task automatic stop();
		#Q o_sda = 1'b0;
		#Q o_scl = 1'b1;
		#Q o_sda = 1'b1;
		#Q;
	endtask
	// Byte out, top bit first; ack when line low
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], r);
		end
		bit_x(1'b1, r);
		ack = ~r;
	endtask
	// ack asks for more, nack ends the read
	task automatic rd_byte(input logic mack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, r);
			d[i] = r;
		end
		bit_x(~mack, r);
	endtask
endmodule

// >>> test/test_spd_eeprom.sv
// Self-checking bench for the EEPROM slave
`timescale 1ns/10ps
module test_spd_eeprom;
	import spd_pkg::*;
	localparam int         WR_CYC = 400;     // Shortened write cycle
	localparam logic [7:0] DEV_W  = 8'hA2;   // Array write, select 001
	localparam logic [7:0] DEV_R  = 8'hA3;   // Array read, select 001
	logic       clk;                         // System clock
	logic       rst_b;                       // Reset, active low
	logic       wp;                          // Protect pin
	logic       hv;                          // Select bit0 at high voltage
	logic [2:0] sel;                         // Select pins
	logic [1:0] reg_addr;                    // Register port
	logic [7:0] reg_wdata;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] rdata;
	logic       busy;                        // Write cycle running
	logic       sda_oe;                      // Device pulls data
	logic       sda_o;
	wire        scl;                         // Link clock
	wire        mst_sda;                     // Master data drive
	wire        sda;                         // Resolved data line
	logic [7:0] exp_mem [256];               // Expected array
	int         err_count;
	int         n_tests;
	// Open drain with pull-up
	assign sda = mst_sda & (sda_oe ? sda_o : 1'b1);
	spd_eeprom #(.P_WR_CYCLES(WR_CYC)) u_dut (
		.I_CLK_SYS(clk), .I_RST_B(rst_b), .I_SCL(scl), .I_SDA(sda), .O_SDA(sda_o),
		.O_SDA_OE(sda_oe), .I_ADDR_SEL(sel), .I_ADDR0_HV(hv), .I_WP(wp), .O_BUSY(busy),
		.I_REG_ADDR(reg_addr), .I_REG_WDATA(reg_wdata), .I_REG_WR(reg_wr),
		.I_REG_RD(reg_rd), .O_REG_RDATA(rdata)
	);
	spd_i2c_master u_mst (.o_scl(scl), .o_sda(mst_sda), .i_sda(sda));
	// Clock
	always #2.5 clk = ~clk;
	// Compare and count
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: saw %h, expected %h", $time, got, exp);
		end
	endtask
	// Counts and verdict
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Register write and read
	task automatic reg_w(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic reg_r(input logic [1:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic peek(input logic [7:0] a, output logic [7:0] d);
		reg_w(REG_PEEK_ADDR, a);
		reg_r(REG_PEEK_DATA, d);
	endtask
	task automatic chk_status(input logic [7:0] exp);
		logic [7:0] d;
		reg_r(REG_STATUS, d);
		chk(d & 8'h07, exp);
	endtask
	// Address byte alone, then Stop
	task automatic cmd(input logic [7:0] dev, input logic ack);
		logic a;
		u_mst.start();
		u_mst.wr_byte(dev, a);
		chk({7'h00, a}, {7'h00, ack});
		u_mst.stop();
	endtask
	// Address, word, n data bytes, Stop
	task automatic wseq(input logic [7:0] dev, w, d0, input int n, input logic ack);
		logic a;
		u_mst.start();
		u_mst.wr_byte(dev, a);
		chk({7'h00, a}, 8'h01);
		u_mst.wr_byte(w, a);
		chk({7'h00, a}, 8'h01);
		for (int i = 0; i < n; i++) begin
			u_mst.wr_byte(d0 + 8'(i), a);
			chk({7'h00, a}, {7'h00, ack});
		end
		u_mst.stop();
	endtask
	// poll until the address is acked
	task automatic wait_idle();
		logic a;
		for (int k = 0; k < 60; k++) begin
			u_mst.start();
			u_mst.wr_byte(DEV_W, a);
			u_mst.stop();
			if (a) return;
		end
		err_count++;
		conclude();
	endtask
	// No write cycle follows
	task automatic no_cycle();
		repeat (20) @(posedge clk);
		chk({7'h00, busy}, 8'h00);
	endtask
	// Dummy write sets the counter, then n reads
	task automatic rd_at(input logic [7:0] a, input int n);
		logic k;
		logic [7:0] d;
		u_mst.start();
		u_mst.wr_byte(DEV_W, k);
		u_mst.wr_byte(a, k);
		u_mst.start();
		u_mst.wr_byte(DEV_R, k);
		chk({7'h00, k}, 8'h01);
		for (int i = 0; i < n; i++) begin
			u_mst.rd_byte(i < n - 1, d);
			chk(d, exp_mem[a + 8'(i)]);
		end
		u_mst.stop();
	endtask
	task automatic t_page();
		logic [7:0] d;
		wseq(DEV_W, 8'hFE, 8'h30, 18, 1'b1);
		cmd(DEV_W, 1'b0);
		chk({7'h00, busy}, 8'h01);
		chk_status(8'h01);
		wait_idle();
		for (int i = 0; i < 18; i++) begin
			exp_mem[{4'hF, 4'hE + 4'(i)}] = 8'h30 + 8'(i);
		end
		for (int i = 0; i < 16; i++) begin
			peek({4'hF, 4'(i)}, d);
			chk(d, exp_mem[{4'hF, 4'(i)}]);
		end
		wseq(DEV_W, 8'h00, 8'hC3, 2, 1'b1);
		exp_mem[0] = 8'hC3;
		exp_mem[1] = 8'hC4;
		wait_idle();
	endtask
	task automatic t_reads();
		logic k;
		logic [7:0] d;
		rd_at(8'hFF, 1);
		u_mst.start();
		u_mst.wr_byte(DEV_R, k);
		u_mst.rd_byte(1'b0, d);
		chk(d, exp_mem[0]);
		u_mst.stop();
		rd_at(8'hFE, 4);
	endtask
	task automatic t_prot();
		logic [7:0] d;
		@(posedge clk) wp <= 1'b1;
		wseq(DEV_W, 8'hF0, 8'h99, 1, 1'b0);
		no_cycle();
		reg_r(REG_STATUS, d);
		chk(d, 8'h08);
		@(posedge clk) hv <= 1'b1;
		cmd(8'h63, 1'b1);
		@(posedge clk) wp <= 1'b0;
		wseq(8'h62, 8'h00, 8'h00, 1, 1'b1);
		wait_idle();
		chk_status(8'h02);
		cmd(8'h63, 1'b0);
		cmd(8'h67, 1'b1);
		wseq(DEV_W, 8'h10, 8'h55, 1, 1'b0);
		no_cycle();
		@(posedge clk) wp <= 1'b1;
		wseq(8'h66, 8'h00, 8'h00, 1, 1'b0);
		@(posedge clk) wp <= 1'b0;
		chk_status(8'h02);
		wseq(8'h66, 8'h00, 8'h00, 1, 1'b1);
		wait_idle();
		chk_status(8'h00);
		@(posedge clk) hv <= 1'b0;
		wseq(8'h62, 8'h00, 8'h00, 1, 1'b1);
		wait_idle();
		chk_status(8'h04);
		cmd(8'h63, 1'b0);
		cmd(8'h62, 1'b0);
		@(posedge clk) hv <= 1'b1;
		cmd(8'h62, 1'b0);
		cmd(8'h67, 1'b0);
		@(posedge clk) hv <= 1'b0;
		wseq(DEV_W, 8'h00, 8'hAA, 1, 1'b0);
		no_cycle();
		peek(8'h00, d);
		chk(d, 8'hC3);
		wseq(DEV_W, 8'hF2, 8'h12, 1, 1'b1);
		wait_idle();
		peek(8'hF2, d);
		chk(d, 8'h12);
	endtask
	// Main sequence
	initial begin
		logic [7:0] d;
		clk = 1'b0;
		rst_b = 1'b0;
		wp = 1'b0;
		hv = 1'b0;
		sel = 3'b001;
		reg_addr = 2'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		err_count = 0;
		n_tests = 0;
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		repeat (5) @(posedge clk);
		chk_status(8'h00);
		reg_r(2'h3, d);
		chk(d, 8'h00);
		cmd(8'hA6, 1'b0);
		@(posedge clk) sel <= 3'b011;
		cmd(8'hA6, 1'b1);
		@(posedge clk) sel <= 3'b001;
		cmd(8'h52, 1'b0);
		t_page();
		t_reads();
		t_prot();
		conclude();
	end
	// Hang limit
	initial begin
		#400000;
		err_count++;
		conclude();
	end
endmodule
